// [verilog/poc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module poc_top #(
  parameter bit HAS_REACTIVE = 1'b1,    // Variant measures reactive power
  parameter bit HAS_FUNDAMENTAL = 1'b1, // Variant measures fundamental power
  parameter int unsigned PWR_W = 24,    // Width of one phase power
  parameter int unsigned ACC_W = 32,    // Converter accumulator width
  parameter int unsigned PULSE_LEN = 8  // Pin active cycles per pulse
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire poc_pkg::poc_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  input wire poc_pkg::poc_power_t phase_power,
  input wire logic [ACC_W-1:0] pulse_threshold,
  input wire logic [2:0][31:0] energy_live,
  output logic [2:0][31:0] energy_latched,
  output logic [2:0] energy_latch_stb,
  output logic [2:0] pulse_sum_negative,
  output logic pulse_out_1,
  output logic pulse_out_2,
  output logic pulse_out_3
);
  import poc_pkg::*;

  localparam int unsigned SUM_W = PWR_W + 2;
  localparam int unsigned LEN_W = $clog2(PULSE_LEN + 1);

  // Elaboration checks; the power carrier fixes the phase width at 24
  if (PWR_W != 24) begin : g_chk_pwr
    $error("poc_top: PWR_W must match the power carrier width of 24");
  end
  if (PULSE_LEN < 1) begin : g_chk_len
    $error("poc_top: PULSE_LEN must be at least 1");
  end
  if (ACC_W <= SUM_W) begin : g_chk_acc
    $error("poc_top: ACC_W must exceed PWR_W + 2");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;                // Pulse output configuration
    logic [8:0] terms;               // Three term bits per output
    logic [15:0] rdata;              // Read data, valid one cycle
    logic [2:0][2:0] sel_live;       // Selection in force per output
    logic [2:0][LEN_W-1:0] pin_cnt;  // Remaining active cycles on pin
    logic [2:0] pin;                 // Pin levels
    logic [2:0][31:0] latched;       // Captured energy per output
    logic [2:0] latch_stb;           // Capture strobe
    logic [2:0] neg;                 // Sign of each output sum
  } poc_st_t;

  poc_st_t st_q; // Registered state
  poc_st_t st_d; // Next state

  logic signed [2:0][SUM_W-1:0] sum; // Selected phase sum per output
  logic [2:0] dfc_pulse;             // Converter pulses
  logic [2:0][2:0] sel_eff;          // Selection after code folding

  // ----------------------------------------------------------------
  // Code folding
  // ----------------------------------------------------------------
  // Reserved codes and codes the variant lacks fall back to total active
  function automatic logic [2:0] poc_fold(input logic [2:0] code);
    logic [2:0] r;
    r = code;
    if (code > 3'h4) begin
      r = 3'h0;
    end else if (code == 3'h1 && !HAS_REACTIVE) begin
      r = 3'h0;
    end else if ((code == 3'h3 || code == 3'h4) && !HAS_FUNDAMENTAL) begin
      r = 3'h0;
    end
    return r;
  endfunction

  always_comb begin
    sel_eff[0] = poc_fold(st_q.cfg[POC_SEL1_LSB +: 3]);
    sel_eff[1] = poc_fold(st_q.cfg[POC_SEL2_LSB +: 3]);
    sel_eff[2] = poc_fold(st_q.cfg[POC_SEL3_LSB +: 3]);
  end

  // ----------------------------------------------------------------
  // Phase summing
  // ----------------------------------------------------------------
  // Only phases whose term bit is set add into an output's sum
  always_comb begin
    logic [2:0][23:0] src;
    src = '0;
    for (int o = 0; o < 3; o++) begin
      unique case (st_q.sel_live[o])
        POC_Q_REACTIVE: src = phase_power.reactive;
        POC_Q_APPARENT: src = phase_power.apparent;
        POC_Q_FUND_ACT: src = phase_power.fund_act;
        POC_Q_FUND_REACT: src = phase_power.fund_react;
        default: src = phase_power.active; // Only code 000 lands here
      endcase
      sum[o] = '0;
      for (int p = 0; p < 3; p++) begin
        if (st_q.terms[o*3 + p]) begin
          sum[o] = sum[o] + SUM_W'($signed(src[p]));
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Converters
  // ----------------------------------------------------------------
  // One converter per output; never gated by the pin disable bits
  for (genvar g = 0; g < 3; g++) begin : g_dfc
    poc_dfc #(
      .SUM_W(SUM_W),
      .ACC_W(ACC_W)
    ) u_dfc (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .power(sum[g]),
      .threshold(pulse_threshold),
      .pulse(dfc_pulse[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    st_d.latch_stb = '0;

    // Register writes; bit 15 keeps no state
    if (bus_req.wr) begin
      if (bus_req.addr == POC_CFG_ADDR) begin
        st_d.cfg = bus_req.wdata & POC_CFG_WMASK;
      end else if (bus_req.addr == POC_TERMS_ADDR) begin
        st_d.terms = bus_req.wdata[8:0];
      end
    end

    // Register reads, answered in the next cycle; unmapped reads give zero
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        POC_CFG_ADDR: st_d.rdata = st_q.cfg;
        POC_TERMS_ADDR: st_d.rdata = {7'h00, st_q.terms};
        POC_STAT_ADDR: st_d.rdata = {10'h000, st_q.neg, st_q.pin};
        default: st_d.rdata = '0;
      endcase
    end

    for (int o = 0; o < 3; o++) begin
      // Sign of each output's sum
      st_d.neg[o] = sum[o][SUM_W-1];

      // Adopt a new selection only while no pulse is on the pin
      if (st_q.pin_cnt[o] == '0) begin
        st_d.sel_live[o] = sel_eff[o];
      end

      // Pin pulse stretcher; the converter keeps counting regardless
      if (st_q.pin_cnt[o] != '0) begin
        st_d.pin_cnt[o] = st_q.pin_cnt[o] - LEN_W'(1);
      end else if (dfc_pulse[o] && !st_q.cfg[POC_DIS_LSB + o]) begin
        st_d.pin_cnt[o] = LEN_W'(PULSE_LEN);
      end

      // Disabled pin idles low; a started pulse is let run out cleanly
      st_d.pin[o] = (st_d.pin_cnt[o] != '0);

      // Capture energy on each converter pulse when enabled
      if (dfc_pulse[o] && st_q.cfg[POC_LATCH_LSB + o]) begin
        st_d.latched[o] = energy_live[o];
        st_d.latch_stb[o] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.cfg <= POC_CFG_RESET;
      st_q.terms <= POC_TERMS_RESET;
      st_q.sel_live[0] <= POC_CFG_RESET[POC_SEL1_LSB +: 3];
      st_q.sel_live[1] <= POC_CFG_RESET[POC_SEL2_LSB +: 3];
      st_q.sel_live[2] <= POC_CFG_RESET[POC_SEL3_LSB +: 3];
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_rdata = st_q.rdata;
  assign energy_latched = st_q.latched;
  assign energy_latch_stb = st_q.latch_stb;
  assign pulse_sum_negative = st_q.neg;
  assign pulse_out_1 = st_q.pin[0];
  assign pulse_out_2 = st_q.pin[1];
  assign pulse_out_3 = st_q.pin[2];

endmodule
`default_nettype wire

// [verilog/poc_pkg.sv]
package poc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned POC_ADDR_W = 16;
  localparam logic [15:0] POC_CFG_ADDR = 16'hE610;   // Pulse output configuration
  localparam logic [15:0] POC_TERMS_ADDR = 16'hE60E; // Per-phase term selection copy
  localparam logic [15:0] POC_STAT_ADDR = 16'hE6F0;  // Live pin and pulse status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned POC_SEL1_LSB = 0;
  localparam int unsigned POC_SEL2_LSB = 3;
  localparam int unsigned POC_SEL3_LSB = 6;
  localparam int unsigned POC_DIS_LSB = 9;
  localparam int unsigned POC_LATCH_LSB = 12;
  localparam int unsigned POC_RSVD_BIT = 15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] POC_CFG_RESET = 16'h0E88;   // sel 000/001/010, dis 111
  localparam logic [8:0] POC_TERMS_RESET = 9'h1FF;    // All phases in all sums
  localparam logic [15:0] POC_CFG_WMASK = 16'h7FFF;   // Bit 15 holds no state

  // ----------------------------------------------------------------
  // Quantity codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    POC_Q_ACTIVE = 3'h0,
    POC_Q_REACTIVE = 3'h1,
    POC_Q_APPARENT = 3'h2,
    POC_Q_FUND_ACT = 3'h3,
    POC_Q_FUND_REACT = 3'h4
  } poc_qty_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } poc_bus_req_t;

  // Per-phase powers, one 3-phase group per quantity
  typedef struct packed {
    logic [2:0][23:0] active;
    logic [2:0][23:0] reactive;
    logic [2:0][23:0] apparent;
    logic [2:0][23:0] fund_act;
    logic [2:0][23:0] fund_react;
  } poc_power_t;

endpackage

// [verilog/poc_dfc.sv]
`timescale 1ns/1ps
`default_nettype none
// Digital-to-frequency converter: accumulates the magnitude of a signed power and fires a
// one-cycle pulse each time the accumulator reaches the threshold.
module poc_dfc #(
  parameter int unsigned SUM_W = 26,
  parameter int unsigned ACC_W = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic signed [SUM_W-1:0] power,
  input wire logic [ACC_W-1:0] threshold,
  output logic pulse
);
  import poc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic pulse;
  } poc_dfc_st_t;

  poc_dfc_st_t st_q; // Registered state
  poc_dfc_st_t st_d; // Next state
  logic [ACC_W-1:0] mag; // Magnitude of the input power

  // Elaboration check: the accumulator must hold a full sum plus headroom
  if (SUM_W >= ACC_W) begin : g_chk_acc
    $error("poc_dfc: ACC_W must exceed SUM_W");
  end

  // Magnitude only; the sign is reported elsewhere, pulses count energy
  always_comb begin
    mag = power[SUM_W-1] ? ACC_W'(-power) : ACC_W'(power);
  end

  // Accumulate and fire; keeps running whatever the pin gating is
  always_comb begin
    st_d = st_q;
    st_d.pulse = 1'b0;
    if (st_q.acc + mag >= threshold) begin
      st_d.acc = st_q.acc + mag - threshold;
      st_d.pulse = 1'b1;
    end else begin
      st_d.acc = st_q.acc + mag;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = st_q.pulse;

endmodule
`default_nettype wire

// [testbench/poc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker for the pulse output block
// ------------------------------------------------------------
module poc_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire poc_pkg::poc_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic [2:0][31:0] energy_live,
  input wire logic [2:0][31:0] energy_latched,
  input wire logic [2:0] energy_latch_stb,
  input wire logic pulse_out_1,
  input wire logic pulse_out_2,
  input wire logic pulse_out_3
);
  import poc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [15:0] cfg_q; // Shadow of the configuration word
  // Shadow tracks writes so gating can be judged without peeking inside
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_q <= POC_CFG_RESET;
    end else if (bus_req.wr && bus_req.addr == POC_CFG_ADDR) begin
      cfg_q <= bus_req.wdata & POC_CFG_WMASK;
    end
  end
  sequence s_rd_cfg;
    bus_req.rd && bus_req.addr == POC_CFG_ADDR;
  endsequence
  // Pin pulse of two active cycles, the length the bench builds the block with
  sequence s_pin_pulse;
    pulse_out_1 [*2] ##1 !pulse_out_1;
  endsequence
  property p_cfg_rd; s_rd_cfg |=> bus_rdata == $past(cfg_q); endproperty
  property p_rsvd; bus_req.rd |=> !bus_rdata[15]; endproperty
  property p_dis1; $rose(pulse_out_1) |-> !$past(cfg_q[9]); endproperty
  property p_dis2; $rose(pulse_out_2) |-> !$past(cfg_q[10]); endproperty
  property p_dis3; $rose(pulse_out_3) |-> !$past(cfg_q[11]); endproperty
  property p_len; $rose(pulse_out_1) |-> s_pin_pulse; endproperty
  property p_lat0; energy_latch_stb[0] |-> energy_latched[0] == $past(energy_live[0]); endproperty
  property p_lat_en; energy_latch_stb[2] |-> cfg_q[14] || $past(cfg_q[14]); endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback differs");
  a_rsvd: assert property (p_rsvd) else $error("top bit read nonzero");
  a_dis1: assert property (p_dis1) else $error("pin 1 pulsed while off");
  a_dis2: assert property (p_dis2) else $error("pin 2 pulsed while off");
  a_dis3: assert property (p_dis3) else $error("pin 3 pulsed while off");
  a_len: assert property (p_len) else $error("pin 1 pulse length wrong");
  a_lat0: assert property (p_lat0) else $error("captured energy wrong");
  a_lat_en: assert property (p_lat_en) else $error("capture without enable");
endmodule
bind poc_top poc_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .energy_live(energy_live), .energy_latched(energy_latched), .energy_latch_stb(energy_latch_stb),
  .pulse_out_1(pulse_out_1), .pulse_out_2(pulse_out_2), .pulse_out_3(pulse_out_3));
`default_nettype wire

// [testbench/poc_pulse_counter.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Meter-side pulse counter, counts rising edges per pin
// ------------------------------------------------------------
module poc_pulse_counter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic pulse_out_1,
  input wire logic pulse_out_2,
  input wire logic pulse_out_3,
  output logic [2:0][15:0] pulse_count
);
  logic [2:0] pin_q; // Previous pin levels
  wire [2:0] pins = {pulse_out_3, pulse_out_2, pulse_out_1};
  // Edge counting only, a level held high counts once
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clr) begin
      pulse_count <= '0;
      pin_q <= pins;
    end else begin
      pin_q <= pins;
      for (int i = 0; i < 3; i++) begin
        pulse_count[i] <= pulse_count[i] + 16'(pins[i] && !pin_q[i]);
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/poc_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module poc_top_tb_top;
  import poc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  poc_bus_req_t bus_req = '0;
  logic [15:0] bus_rdata;
  logic [4:0][2:0][23:0] pw = '0; // Quantity groups, active in the top slot
  logic [31:0] thr = 32'h0000012C; // Large enough to space pulses apart
  logic [2:0][31:0] live = {32'h00003333, 32'h00002222, 32'h00001111};
  logic [2:0][31:0] latched;
  logic [2:0] stb;
  logic [2:0] neg;
  logic [2:0] neg_lite; // Sign flags of the reduced variant
  logic pin1, pin2, pin3;
  logic clr = 1'b0;
  logic [2:0][15:0] cnt;
  int err_total = 0;
  int compares = 0;
  int stb_cnt = 0;
  always #5 clk_sys = ~clk_sys;
  // Converter activity seen through the capture strobes
  always @(posedge clk_sys) begin
    if (stb !== 3'b000) stb_cnt <= stb_cnt + 1;
  end
  poc_top #(.PULSE_LEN(2)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .phase_power(poc_power_t'(pw)), .pulse_threshold(thr), .energy_live(live), .energy_latched(latched),
    .energy_latch_stb(stb), .pulse_sum_negative(neg), .pulse_out_1(pin1), .pulse_out_2(pin2), .pulse_out_3(pin3));
  // Variant without reactive or fundamental measurement, same stimulus
  poc_top #(.HAS_REACTIVE(1'b0), .HAS_FUNDAMENTAL(1'b0), .PULSE_LEN(2)) i_dut_lite (.clk_sys(clk_sys),
    .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(), .phase_power(poc_power_t'(pw)), .pulse_threshold(thr),
    .energy_live(live), .energy_latched(), .energy_latch_stb(), .pulse_sum_negative(neg_lite), .pulse_out_1(),
    .pulse_out_2(), .pulse_out_3());
  poc_pulse_counter i_cnt (.clk_sys(clk_sys), .rst_n(rst_n), .clr(clr), .pulse_out_1(pin1), .pulse_out_2(pin2),
    .pulse_out_3(pin3), .pulse_count(cnt));
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(string what, logic [15:0] a, logic [15:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 chk(what, 32'(exp), 32'(bus_rdata));
  endtask
  task automatic run(int n);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd_chk("cfg reset", POC_CFG_ADDR, 16'h0E88);
    rd_chk("terms reset", POC_TERMS_ADDR, 16'h01FF);
    rd_chk("unmapped", 16'h0000, 16'h0000);
    wr(POC_CFG_ADDR, 16'hFFFF);
    rd_chk("cfg top bit", POC_CFG_ADDR, 16'h7FFF);
  endtask
  // One quantity goes negative, the sign flags show which one is in use
  task automatic t_select();
    logic [2:0] c;
    logic [2:0] eff_lite;
    logic [31:0] want;
    for (int q = 0; q < 5; q++) begin
      @(posedge clk_sys);
      for (int g = 0; g < 5; g++) pw[g] <= {3{(4 - g == q) ? 24'hFFFFF6 : 24'h00000A}};
      for (int k = 0; k < 8; k++) begin
        c = 3'(k);
        // Reduced variant keeps only total active and apparent
        eff_lite = (k == 0 || k == 2) ? c : 3'h0;
        want = ((k > 4 ? 0 : k) == q) ? 32'h7 : 32'h0;
        wr(POC_CFG_ADDR, {7'h07, c, c, c});
        repeat (6) @(posedge clk_sys);
        #1;
        chk("sum sign", want, 32'(neg));
        chk("lite sum sign", (32'(eff_lite) == 32'(q)) ? 32'h7 : 32'h0, 32'(neg_lite));
        rd_chk("status sign", POC_STAT_ADDR, 16'(want << 3));
      end
    end
  endtask
  // Phase A alone is negative, so dropping it flips the sign
  task automatic t_terms();
    logic [8:0] terms [4] = '{9'h1FF, 9'h1B6, 9'h1F7, 9'h1BF};
    logic [2:0] exp [4] = '{3'b111, 3'b000, 3'b101, 3'b011};
    @(posedge clk_sys);
    pw[4] <= {24'h00000A, 24'h00000A, 24'hFFFFE2};
    wr(POC_CFG_ADDR, 16'h0E00);
    for (int i = 0; i < 4; i++) begin
      wr(POC_TERMS_ADDR, 16'(terms[i]));
      repeat (6) @(posedge clk_sys);
      chk("phase terms", 32'(exp[i]), 32'(neg));
    end
    wr(POC_TERMS_ADDR, 16'h01FF);
  endtask
  // Pins released from gating, pin 2 first and then all three, while converters keep running
  task automatic t_pins();
    logic [15:0] cfg [3] = '{16'h3E00, 16'h3A00, 16'h3000};
    logic [2:0] exp [3] = '{3'b000, 3'b010, 3'b111};
    int base;
    @(posedge clk_sys);
    pw[4] <= {3{24'h00000A}};
    for (int i = 0; i < 3; i++) begin
      wr(POC_CFG_ADDR, cfg[i]);
      base = stb_cnt;
      run(100);
      chk("pins active", 32'(exp[i]), {29'h0, |cnt[2], |cnt[1], |cnt[0]});
      chk("converter runs", 32'h1, 32'(stb_cnt > base));
    end
    chk("latch 1", live[0], latched[0]);
    chk("latch 3 off", 32'h0, latched[2]);
  endtask
  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_select();
    t_terms();
    t_pins();
    final_report();
  end
endmodule
`default_nettype wire
